// file: src/pic_oc_map.vh
// Behaviour
// RQ1: Odd port writes mask; even port D4:D3 00 is EOI word, 01 mode word.
// RQ2: Command words accepted any time after initialization completes.
// RQ3: Set mask bit blocks that line; clear bit lets it interrupt.
// RQ4: Mask gates request register output; masked lines still latch requests.
// RQ5: Odd port read returns the mask register.
// RQ6: Rotate, specific-level, EOI bits decode into eight commands.
// RQ7: Auto-EOI rotation rotates at acknowledge end; clear command stops it.
// RQ8: Non-specific EOI clears top in-service bit; rotating form also rotates.
// RQ9: Specific EOI clears named in-service bit; rotating form also rotates.
// RQ10: Set priority makes named line lowest; level used only by specific EOI and set priority.
// RQ11: Host writes D4 and D3 zero in the priority/EOI word.
// RQ12: Special masking changes only with its enable; lets lower interrupt.
// RQ13: Even port read returns in-service if read target set, else request.
// RQ14: Read target updates only with its enable bit; persists across reads.
// RQ15: Finishing initialization clears read target.
// RQ16: After poll, next selected read acknowledges and sets winner in-service.
// RQ17: Poll byte bit 7 flags a request, low bits give winning line.
// RQ18: Pending poll beats register read select.
// RQ19: Host polls by writing command then reading; issues EOI per request.
// RQ20: Host fully initializes before relying on polling.
// RQ21: Priority is circular, line 0 highest at init; rotation puts line last.
`ifndef PIC_OC_MAP_VH
`define PIC_OC_MAP_VH
`define PIC_D_SEL_HI 4
`define PIC_D_SEL_LO 3
`define PIC_D_ROT 7
`define PIC_D_SL 6
`define PIC_D_EOI 5
`define PIC_D_LVL_HI 2
`define PIC_D_LVL_LO 0
`define PIC_D_SPECIAL_MASKING_WRITE_EN 6
`define PIC_D_SMM 5
`define PIC_D_POLL 2
`define PIC_D_ERR 1
`define PIC_D_READ_TARGET 0
`define PIC_CMD_AROT_CLR 3'h0
`define PIC_CMD_NS_EOI 3'h1
`define PIC_CMD_NOP 3'h2
`define PIC_CMD_SP_EOI 3'h3
`define PIC_CMD_AROT_SET 3'h4
`define PIC_CMD_ROT_NS 3'h5
`define PIC_CMD_SET_PRI 3'h6
`define PIC_CMD_ROT_SP 3'h7
`define PIC_MASK_RST 8'h00
`define PIC_BASE_RST 3'h0
`define PIC_POLL_FLAG 7
`endif

// file: src/pic_oc_sync.v
`timescale 1ns/1ps
// ==========================================
// Three-stage synchroniser for request pins
module pic_oc_sync (
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  input wire [7:0] raw_in,
  output reg [7:0] level_out
);
  reg [7:0] s1_q;
  reg [7:0] s2_q;
  reg [7:0] s3_q;
  always @(posedge clk_in) begin
    if (reset_in) begin
      s1_q <= 8'h00;
      s2_q <= 8'h00;
      s3_q <= 8'h00;
      level_out <= 8'h00;
    end else if (ce_in) begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_out <= (s2_q & s3_q) | (level_out & (s2_q | s3_q));
    end
  end
endmodule // pic_oc_sync

// file: src/pic_oc_top.v
`timescale 1ns/1ps
`include "pic_oc_map.vh"
module pic_oc_top (
  input wire clk_in,
  input wire reset_in,
  input wire ce_in,
  input wire init_done_in,
  input wire aeoi_mode_in,
  input wire cs_in,
  input wire wr_in,
  input wire rd_in,
  input wire port_select_hi_in,
  input wire [7:0] wdata_in,
  input wire [7:0] request_line_in,
  input wire inta_in,
  output reg [7:0] rdata_out,
  output reg int_out,
  output reg [2:0] ack_line_out,
  output reg ack_valid_out,
  output reg special_masking_out,
  output reg read_target_out,
  output reg poll_pending_out
);
  // ==========================================
  // Priority helpers
  // Position of line in circular order, 0 highest
  function [2:0] pic_rank;
    input [2:0] line;
    input [2:0] base;
    begin
      pic_rank = line - base;
    end
  endfunction
  // Highest-priority set bit of vec; found flag in bit 3
  function [3:0] pic_pick;
    input [7:0] vec;
    input [2:0] base;
    integer k;
    reg [2:0] cand;
    reg hit;
    begin
      hit = 1'b0;
      cand = 3'h0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (vec[base + k[2:0]]) begin
          hit = 1'b1;
          cand = base + k[2:0];
        end
      end
      pic_pick = {hit, cand};
    end
  endfunction
  function [7:0] pic_onehot;
    input [2:0] line;
    begin
      pic_onehot = 8'h01 << line;
    end
  endfunction

  // ==========================================
  // State
  reg [7:0] line_masks_q;
  reg [7:0] req_q;
  reg [7:0] isr_q;
  reg [2:0] base_q;
  reg arot_q;
  reg started_q;
  reg init_prev_q;
  reg rd_prev_q;
  reg inta_prev_q;
  wire [7:0] req_sync;

  pic_oc_sync u_sync (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .raw_in(request_line_in),
    .level_out(req_sync)
  );

  // ==========================================
  // Decode and arbitration
  wire wr_ok = cs_in & wr_in & started_q; // RQ2
  wire wr_mask = wr_ok & port_select_hi_in; // RQ1
  wire wr_even = wr_ok & ~port_select_hi_in;
  wire wr_eoi = wr_even & ~wdata_in[`PIC_D_SEL_HI]
    & ~wdata_in[`PIC_D_SEL_LO]; // RQ1
  wire wr_mode = wr_even & ~wdata_in[`PIC_D_SEL_HI]
    & wdata_in[`PIC_D_SEL_LO]; // RQ1
  wire [2:0] cmd = {wdata_in[`PIC_D_ROT], wdata_in[`PIC_D_SL],
    wdata_in[`PIC_D_EOI]}; // RQ6
  wire [2:0] lvl = wdata_in[`PIC_D_LVL_HI:`PIC_D_LVL_LO];
  wire rd_rise = cs_in & rd_in & ~rd_prev_q;
  wire inta_fall = inta_prev_q & ~inta_in;
  wire init_rise = init_done_in & ~init_prev_q;

  wire [7:0] live = req_q & ~line_masks_q; // RQ3 RQ4
  wire [3:0] top_req = pic_pick(live, base_q);
  wire [3:0] top_isr = pic_pick(isr_q, base_q);
  // In special masking an in-service line blocks only itself
  wire [7:0] eligible = special_masking_out ? (live & ~isr_q) : live; // RQ12
  wire [3:0] top_elig = pic_pick(eligible, base_q);
  wire win = top_elig[3] & (special_masking_out | ~top_isr[3] |
    (pic_rank(top_elig[2:0], base_q) < pic_rank(top_isr[2:0], base_q)));

  reg [7:0] isr_d;
  reg [2:0] base_d;
  reg arot_d;
  always @* begin
    isr_d = isr_q;
    base_d = base_q;
    arot_d = arot_q;
    if (wr_eoi) begin
      case (cmd) // RQ6
        `PIC_CMD_AROT_CLR: arot_d = 1'b0; // RQ7
        `PIC_CMD_AROT_SET: arot_d = 1'b1; // RQ7
        `PIC_CMD_NS_EOI: isr_d = isr_q & ~pic_onehot(top_isr[2:0]); // RQ8
        `PIC_CMD_ROT_NS: begin
          if (top_isr[3]) begin
            isr_d = isr_q & ~pic_onehot(top_isr[2:0]); // RQ8
            base_d = top_isr[2:0] + 3'h1; // RQ21
          end
        end
        `PIC_CMD_SP_EOI: isr_d = isr_q & ~pic_onehot(lvl); // RQ9
        `PIC_CMD_ROT_SP: begin
          isr_d = isr_q & ~pic_onehot(lvl); // RQ9
          base_d = lvl + 3'h1; // RQ21
        end
        `PIC_CMD_SET_PRI: base_d = lvl + 3'h1; // RQ10
        default: ;
      endcase
    end
    // Poll read acknowledges the winner
    if (rd_rise && poll_pending_out && win) begin
      isr_d = isr_d | pic_onehot(top_elig[2:0]); // RQ16
    end else if (inta_fall && ack_valid_out) begin
      if (aeoi_mode_in) begin
        if (arot_q) begin
          base_d = ack_line_out + 3'h1; // RQ7
        end
      end else begin
        isr_d = isr_d | pic_onehot(ack_line_out);
      end
    end
  end

  // ==========================================
  // Registers
  always @(posedge clk_in) begin
    if (reset_in) begin
      line_masks_q <= `PIC_MASK_RST;
      req_q <= 8'h00;
      isr_q <= 8'h00;
      base_q <= `PIC_BASE_RST;
      arot_q <= 1'b0;
      started_q <= 1'b0;
      init_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      inta_prev_q <= 1'b0;
      rdata_out <= 8'h00;
      int_out <= 1'b0;
      ack_line_out <= 3'h0;
      ack_valid_out <= 1'b0;
      special_masking_out <= 1'b0;
      read_target_out <= 1'b0;
      poll_pending_out <= 1'b0;
    end else if (ce_in) begin
      init_prev_q <= init_done_in;
      rd_prev_q <= cs_in & rd_in;
      inta_prev_q <= inta_in;
      req_q <= req_sync; // RQ4
      isr_q <= isr_d;
      base_q <= base_d;
      arot_q <= arot_d;
      int_out <= win & ~poll_pending_out; // RQ3
      if (init_rise) begin
        started_q <= 1'b1;
        read_target_out <= 1'b0; // RQ15
        base_q <= `PIC_BASE_RST; // RQ21
        poll_pending_out <= 1'b0;
      end
      if (wr_mask) begin
        line_masks_q <= wdata_in; // RQ1
      end
      if (wr_mode) begin
        if (wdata_in[`PIC_D_SPECIAL_MASKING_WRITE_EN]) begin
          special_masking_out <= wdata_in[`PIC_D_SMM]; // RQ12
        end
        if (wdata_in[`PIC_D_ERR] && !init_rise) begin
          read_target_out <= wdata_in[`PIC_D_READ_TARGET]; // RQ14
        end
        if (wdata_in[`PIC_D_POLL]) begin
          poll_pending_out <= 1'b1;
        end
      end
      if (inta_in && !inta_prev_q) begin
        ack_valid_out <= win;
        ack_line_out <= top_elig[2:0];
      end
      if (rd_rise) begin
        if (poll_pending_out) begin
          // A poll written in the same cycle stays armed
          poll_pending_out <= wr_mode & wdata_in[`PIC_D_POLL];
          rdata_out <= {win, 4'h0, top_elig[2:0]}; // RQ16 RQ17 RQ18
        end else if (port_select_hi_in) begin
          rdata_out <= line_masks_q; // RQ5
        end else begin
          rdata_out <= read_target_out ? isr_q : req_q; // RQ13
        end
      end
    end
  end
endmodule // pic_oc_top

// file: dv/pic_oc_host.sv
`timescale 1ns/1ps
// ==========
// Host core port model
module pic_oc_host (
  input wire clk_in,
  output reg cs_out,
  output reg wr_out,
  output reg rd_out,
  output reg hi_out,
  output reg [7:0] wd_out
);
  event rd_ev;
  initial {cs_out, wr_out, rd_out, hi_out, wd_out} = 12'h000;
  // One cycle strobe for writes, two for reads
  task op(input logic r, h, input logic [7:0] d);
    @(negedge clk_in);
    {cs_out, wr_out, rd_out, hi_out, wd_out} <= {1'h1, ~r, r, h, d};
    repeat (r + 1) @(negedge clk_in);
    {cs_out, wr_out, rd_out, wd_out} <= {3'h0, ~d};
    @(negedge clk_in);
    if (r) ->rd_ev;
  endtask
endmodule // pic_oc_host

// file: dv/pic_oc_top_chk.sv
`timescale 1ns/1ps
// ==========
// Port checker
module pic_oc_top_chk (
  input wire clk_in,
  input wire reset_in,
  input wire init_done_in,
  input wire cs_in,
  input wire wr_in,
  input wire rd_in,
  input wire port_select_hi_in,
  input wire [7:0] wdata_in,
  input wire [7:0] rdata_out,
  input wire int_out,
  input wire special_masking_out,
  input wire read_target_out,
  input wire poll_pending_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  reg rd_q;
  reg arm_q;
  wire rd_up = cs_in & rd_in & ~rd_q;
  wire mw = cs_in & wr_in & ~port_select_hi_in & init_done_in & arm_q
    & (wdata_in[4:3] == 2'h1);
  always @(posedge clk_in) {rd_q, arm_q} <= {~reset_in & cs_in & rd_in,
    init_done_in};
  sequence s_poll_arm;
    mw && wdata_in[2];
  endsequence
  sequence s_poll_read;
    poll_pending_out && rd_up;
  endsequence
  a_poll_arms: assert property (s_poll_arm |=> poll_pending_out)
    else $error("poll not armed");
  a_poll_byte: assert property (s_poll_read |=> !poll_pending_out
    && rdata_out[6:3] == 4'h0) else $error("poll byte wrong");
  a_poll_quiet: assert property (poll_pending_out [*2] |-> !int_out)
    else $error("int while poll pending");
  a_read_target_load: assert property (mw && wdata_in[1] |=>
    read_target_out == $past(wdata_in[0])) else $error("read_target load");
  a_read_target_keep: assert property (!(mw && wdata_in[1]) && arm_q |=>
    $stable(read_target_out)) else $error("read_target moved");
  a_smm_load: assert property (mw && wdata_in[6] |=>
    special_masking_out == $past(wdata_in[5])) else $error("smm load");
  a_smm_keep: assert property (!(mw && wdata_in[6]) && arm_q |=>
    $stable(special_masking_out)) else $error("smm moved");
  a_read_hold: assert property (!rd_up |=> $stable(rdata_out))
    else $error("read data moved");
endmodule // pic_oc_top_chk
bind pic_oc_top pic_oc_top_chk chk (.*);

// file: dv/pic_oc_top_tb.sv
`timescale 1ns/1ps
module pic_oc_top_tb;
  logic clk_in = 1'h0, reset_in = 1'h1, init_done_in = 1'h0;
  logic cs_in, wr_in, rd_in, port_select_hi_in, int_out;
  logic [7:0] wdata_in, rdata_out, r;
  logic [7:0] request_line_in = 8'h00;
  logic aeoi_mode_in = 1'h0, inta_in = 1'h0, ack_valid_out;
  logic [2:0] ack_line_out;
  logic [7:0] eq[$];
  logic [31:0] lf = 32'h8323;
  logic [2:0] w, top;
  int fail_count = 0, samples_checked = 0;
  // ==========
  // Clock, design and host model
  initial forever #10 clk_in = ~clk_in;
  pic_oc_top dut (.*, .ce_in(1'h1), .special_masking_out(),
    .read_target_out(), .poll_pending_out());
  pic_oc_host host (.clk_in(clk_in), .cs_out(cs_in), .wr_out(wr_in),
    .rd_out(rd_in), .hi_out(port_select_hi_in), .wd_out(wdata_in));
  // ==========
  // Helpers
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [2:0] win(input logic [7:0] v, logic [2:0] b);
    for (int i = 0; i < 8; i++)
      if (v[3'(b + i)]) return 3'(b + i);
    return 3'h0;
  endfunction
  task chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task rx(input logic h, input logic [7:0] e);
    eq.push_back(e);
    host.op(1'h1, h, 8'h00);
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(host.rd_ev) chk("rdata", rdata_out, eq.pop_front());
  initial begin
    #100000;
    fail_count++;
    wrap_up();
  end
  // ==========
  // Scenarios
  initial begin
    repeat (12) @(posedge clk_in);
    @(negedge clk_in);
    reset_in <= 1'h0;
    host.op(1'h0, 1'h1, 8'hA5);
    init_done_in <= 1'h1;
    rx(1'h1, 8'h00);
    rx(1'h0, 8'h00);
    repeat (4) begin
      lf = nx(lf);
      host.op(1'h0, 1'h1, lf[7:0]);
      rx(1'h1, lf[7:0]);
    end
    r = lf[15:8] | 8'h11;
    host.op(1'h0, 1'h1, 8'hFF);
    request_line_in <= r;
    repeat (8) @(negedge clk_in);
    chk("int", {7'h00, int_out}, 8'h00);
    rx(1'h0, r);
    host.op(1'h0, 1'h1, 8'h00);
    repeat (3) @(negedge clk_in);
    chk("int", {7'h00, int_out}, 8'h01);
    host.op(1'h0, 1'h0, 8'h0B);
    rx(1'h0, 8'h00);
    host.op(1'h0, 1'h0, 8'h08);
    host.op(1'h0, 1'h0, 8'h1A);
    rx(1'h0, 8'h00);
    host.op(1'h0, 1'h0, 8'h68);
    host.op(1'h0, 1'h0, 8'h48);
    top = 3'h0;
    for (int c = 0; c < 8; c++) begin
      w = win(r, top);
      host.op(1'h0, 1'h0, 8'h0C);
      rx(c[0], {5'h10, w});
      host.op(1'h0, 1'h0, {c[2:0], 2'h0, w});
      rx(1'h0, c[0] ? 8'h00 : 8'h01 << w);
      if (c >= 5) top = w + 3'h1;
      host.op(1'h0, 1'h0, {5'h0C, w});
    end
    // Acknowledge cycle, normal then automatic end of interrupt
    w = win(r, top);
    inta_in <= 1'h1;
    repeat (2) @(negedge clk_in);
    chk("ack_valid", {7'h00, ack_valid_out}, 8'h01);
    chk("ack_line", {5'h00, ack_line_out}, {5'h00, w});
    inta_in <= 1'h0;
    rx(1'h0, 8'h01 << w);
    host.op(1'h0, 1'h0, {5'h0C, w});
    aeoi_mode_in <= 1'h1;
    host.op(1'h0, 1'h0, 8'h80);
    inta_in <= 1'h1;
    repeat (2) @(negedge clk_in);
    chk("ack_line", {5'h00, ack_line_out}, {5'h00, w});
    inta_in <= 1'h0;
    rx(1'h0, 8'h00);
    top = w + 3'h1;
    host.op(1'h0, 1'h0, 8'h0C);
    rx(1'h0, {5'h10, win(r, top)});
    wrap_up();
  end
endmodule // pic_oc_top_tb
